// [rtl/spi_prog.sv]
// What the document requires of this block and its programmer
// R01 - Programming enable must be accepted before any program or erase runs.
// R02 - Chip erase sets all flash and EEPROM locations to 0xFF.
// R03 - EEPROM writes erase their location automatically, no chip erase needed.
// R04 - Programmer keeps each serial clock phase over 2 or 3 CPU clocks.
// R05 - Incoming bits are sampled on the serial clock rising edge.
// R06 - Outgoing bits are shifted out on the serial clock falling edge.
// R07 - Programmer holds reset and serial clock low at power-up.
// R08 - Programmer waits 20ms after power-up before the enable instruction; the testbench waits 4 clocks.
// R09 - Enable is AC 53 00 00; second byte echoes during the third byte.
// R10 - Programmer sends all four enable bytes, re-pulses reset on bad echo; the testbench only counts a bad echo as a failure.
// R11 - Flash page loads use 6 address LSBs, 0x40 low then 0x48 high.
// R12 - Opcode 0x4C commits the page buffer to the page from 7 MSBs.
// R13 - Without polling, programmer waits 2.6ms after a flash page write.
// R14 - EEPROM byte write 0xC0, address bytes 2-3, data byte 4, 3.6ms.
// R15 - EEPROM page commit 0xC2 changes only bytes loaded by 0xC1.
// R16 - Reads 0x20, 0x28, 0xA0 return addressed data during byte 4.
// R17 - Poll 0xF0 returns LSB 1 while a write is still pending.
// R18 - Chip erase is AC 80 00 00, taking 10.5ms without polling.
// R19 - Fuse and lock writes AC E0/A0/A8/A4 with data byte 4, 4.5ms.
// R20 - Fuse and lock reads 58/00, 50/00, 58/08, 50/08; zero is programmed.
// R21 - Program memory instructions use a word address anywhere in range.
// R22 - Opcode 0x4D loads extended address bits from byte 3.
// R23 - Programmer leaves unused fuse and lock bits as ones.
// R24 - Programmer releases reset high to end the session.
// R25 - Instructions are four bytes MSB first, decoded after the fourth byte.
`timescale 1ns/1ps
`default_nettype none

// Received-byte queue between the link and the instruction executor
module byte_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);

    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("byte_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;

    // Full compares the pointer distance, so all D slots are usable
    assign in_ready  = (wr_ptr - rd_ptr) != FULL;
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Storage write
    always_ff @(posedge mclk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

module spi_prog #(
    parameter int FLASH_AW    = 13,
    parameter int FIFO_DEPTH  = 8,
    parameter int FLASH_WAIT  = prog_pkg::FLASH_WAIT_CYC,
    parameter int EEPROM_WAIT = prog_pkg::EEPROM_WAIT_CYC,
    parameter int ERASE_WAIT  = prog_pkg::ERASE_WAIT_CYC,
    parameter int FUSE_WAIT   = prog_pkg::FUSE_WAIT_CYC
) (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic prog_rst_n,
    input  wire logic sck,
    input  wire logic sdi,
    output logic      sdo,
    output logic      prog_enabled,
    output logic      write_pending_flag,
    output logic      rx_overrun
);
    import prog_pkg::*;

    // A busy window under two cycles would hold the pending flag for less than the two cycles pending_a checks
    if (FLASH_AW < PAGE_AW + 1 || FLASH_AW < EE_AW || FLASH_AW > 24
        || FLASH_WAIT < 2 || EEPROM_WAIT < 2 || ERASE_WAIT < 2
        || FUSE_WAIT < 2) begin : g_bad_param
        $error("spi_prog parameters out of range");
    end

    // Pin synchronisers; only the second stage onward is looked at
    logic [2:0] sck_q;
    logic [1:0] sdi_q;
    logic [1:0] rstp_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sck_q  <= '0;
            sdi_q  <= '0;
            rstp_q <= 2'b11;
        end else begin
            sck_q  <= {sck_q[1:0], sck};
            sdi_q  <= {sdi_q[0], sdi};
            rstp_q <= {rstp_q[0], prog_rst_n};
        end
    end

    logic       sck_rise;
    logic       sck_fall;
    logic       session;
    logic       byte_done;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] tx_sh;
    logic [7:0] read_byte;

    assign sck_rise  = sck_q[1] && !sck_q[2];
    assign sck_fall  = !sck_q[1] && sck_q[2];
    assign session   = !rstp_q[1];
    assign rx_byte   = {rx_sh[6:0], sdi_q[1]};
    assign byte_done = sck_rise && bit_cnt == 3'h7;

    // Executor state, memories and fuses
    exec_state_t         state;
    instr_t              cur;
    logic                instr_valid;
    logic [1:0]          asm_cnt;
    logic [7:0]          ext_addr;
    logic [FLASH_AW-1:0] sweep;
    logic [PAGE_NUM_W-1:0] page;
    logic [31:0]         wait_cnt;
    logic [7:0]          lock_bits;
    logic [7:0]          fuse_lo;
    logic [7:0]          fuse_hi;
    logic [7:0]          fuse_ext;
    logic [15:0]         flash [2**FLASH_AW];
    logic [7:0]          ee [2**EE_AW];
    logic [7:0]          pbuf_lo [2**PAGE_AW];
    logic [7:0]          pbuf_hi [2**PAGE_AW];
    logic [7:0]          ebuf [2**EE_PAGE_AW];
    logic [3:0]          emask;
    logic [FLASH_AW-1:0] rd_word;
    logic [EE_AW-1:0]    ee_addr;
    logic                go;
    logic [15:0]         page_addr;

    // Word address, extended bits on top, free within the flash range
    assign rd_word = FLASH_AW'({ext_addr, b2, rx_byte}); // R21 R22
    assign ee_addr = {cur.b2[1:0], cur.b3};
    assign go      = instr_valid && state == ST_IDLE && prog_enabled; // R01
    // Commit address as one word, so the page field can be sliced out
    assign page_addr = {cur.b2, cur.b3};

    // Byte sent during byte 4, chosen once byte 3 has arrived
    always_comb begin
        case (b1)
            OP_RD_LO:     read_byte = flash[rd_word][7:0]; // R16
            OP_RD_HI:     read_byte = flash[rd_word][15:8]; // R16
            OP_RD_EE:     read_byte = ee[{b2[1:0], rx_byte}]; // R16
            OP_POLL:      read_byte = {7'h0, write_pending_flag}; // R17
            OP_RD_LOCKHI: read_byte = (b2 == SUB_RD_UPPER) ? fuse_hi
                                                            : lock_bits; // R20
            OP_RD_FUSE:   read_byte = (b2 == SUB_RD_UPPER) ? fuse_ext
                                                            : fuse_lo; // R20
            default:      read_byte = rx_byte;
        endcase
    end

    // Link shifter; a high reset pin drops the frame so the host can resync
    always_ff @(posedge mclk) begin
        if (!resetn || !session) begin
            rx_sh    <= '0;
            bit_cnt  <= '0;
            byte_idx <= '0;
            b1       <= '0;
            b2       <= '0;
            tx_sh    <= '0;
            sdo      <= 1'b0;
        end else if (sck_rise) begin
            rx_sh   <= rx_byte; // R05
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                byte_idx <= byte_idx + 2'h1; // R25
                if (byte_idx == 2'h0) begin
                    b1 <= rx_byte;
                end
                if (byte_idx == 2'h1) begin
                    b2 <= rx_byte;
                end
                // Each byte echoes next time unless byte 4 carries data
                tx_sh <= (byte_idx == 2'h2) ? read_byte : rx_byte; // R09
            end
        end else if (sck_fall) begin
            sdo   <= tx_sh[7]; // R06
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    logic       fifo_in_ready;
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_pop;

    // Sweeps stall the drain, so a host that ignores busy fills the queue
    assign fifo_pop = fifo_valid && state != ST_ERASE && state != ST_PAGE;

    byte_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn && session),
        .in_data   (rx_byte),
        .in_valid  (byte_done && session),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // A byte that finds the queue full is lost; flag stays until session end
    always_ff @(posedge mclk) begin
        if (!resetn || !session) begin
            rx_overrun <= 1'b0;
        end else if (byte_done && !fifo_in_ready) begin
            rx_overrun <= 1'b1;
        end
    end

    // Four bytes make one instruction, first byte is the opcode
    always_ff @(posedge mclk) begin
        if (!resetn || !session) begin
            asm_cnt     <= '0;
            instr_valid <= 1'b0;
            cur         <= '0;
        end else begin
            instr_valid <= fifo_pop && asm_cnt == 2'h3; // R25
            if (fifo_pop) begin
                asm_cnt <= asm_cnt + 2'h1;
                case (asm_cnt)
                    2'h0:    cur.op <= fifo_data;
                    2'h1:    cur.b2 <= fifo_data;
                    2'h2:    cur.b3 <= fifo_data;
                    default: cur.b4 <= fifo_data;
                endcase
            end
        end
    end

    // Enable latch, cleared whenever the reset pin goes high
    always_ff @(posedge mclk) begin
        if (!resetn || !session) begin
            prog_enabled <= 1'b0;
        end else if (instr_valid && cur.op == OP_ENABLE_1
                     && cur.b2 == OP_ENABLE_2) begin
            prog_enabled <= 1'b1; // R01
        end
    end

    // Sequencer: erase and page sweeps, then the self-timed wait
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state     <= ST_IDLE;
            sweep     <= '0;
            page      <= '0;
            wait_cnt  <= '0;
            ext_addr  <= '0;
            lock_bits <= LOCK_RST;
            fuse_lo   <= FUSE_LO_RST;
            fuse_hi   <= FUSE_HI_RST;
            fuse_ext  <= FUSE_EXT_RST;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        case (cur.op)
                            OP_ENABLE_1: begin
                                if (cur.b2 == SUB_ERASE) begin
                                    state     <= ST_ERASE; // R18
                                    sweep     <= '0;
                                    lock_bits <= ERASED_BYTE;
                                end else if (cur.b2 == SUB_LOCK
                                             || cur.b2 == SUB_FUSE_LO
                                             || cur.b2 == SUB_FUSE_HI
                                             || cur.b2 == SUB_FUSE_EXT) begin
                                    state    <= ST_WAIT; // R19
                                    wait_cnt <= 32'(FUSE_WAIT - 1);
                                end
                                if (cur.b2 == SUB_LOCK) begin
                                    lock_bits <= cur.b4; // R19
                                end
                                if (cur.b2 == SUB_FUSE_LO) begin
                                    fuse_lo <= cur.b4; // R19
                                end
                                if (cur.b2 == SUB_FUSE_HI) begin
                                    fuse_hi <= cur.b4; // R19
                                end
                                if (cur.b2 == SUB_FUSE_EXT) begin
                                    fuse_ext <= cur.b4; // R19
                                end
                            end
                            OP_WR_PAGE: begin
                                state <= ST_PAGE; // R12
                                sweep <= '0;
                                page  <= page_addr[PAGE_AW +: PAGE_NUM_W];
                            end
                            OP_WR_EE, OP_WR_EEPG: begin
                                state    <= ST_WAIT; // R14
                                wait_cnt <= 32'(EEPROM_WAIT - 1);
                            end
                            OP_EXT_ADDR: ext_addr <= cur.b3; // R22
                            default: ;
                        endcase
                    end
                end
                ST_ERASE: begin
                    sweep <= sweep + 1'b1;
                    if (&sweep) begin
                        state    <= ST_WAIT;
                        wait_cnt <= 32'(ERASE_WAIT - 1);
                    end
                end
                ST_PAGE: begin
                    sweep <= sweep + 1'b1;
                    if (&sweep[PAGE_AW-1:0]) begin
                        state    <= ST_WAIT;
                        wait_cnt <= 32'(FLASH_WAIT - 1);
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 32'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Busy flag seen by the poll instruction
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            write_pending_flag <= 1'b0;
        end else begin
            write_pending_flag <= state != ST_IDLE; // R17
        end
    end

    // Flash page buffer; low and high byte of a word load separately
    always_ff @(posedge mclk) begin
        if (go && cur.op == OP_LD_LO) begin
            pbuf_lo[cur.b3[PAGE_AW-1:0]] <= cur.b4; // R11
        end
        if (go && cur.op == OP_LD_HI) begin
            pbuf_hi[cur.b3[PAGE_AW-1:0]] <= cur.b4; // R11
        end
    end

    // Flash array: erase sweep or page commit, one word a cycle
    always_ff @(posedge mclk) begin
        if (state == ST_ERASE) begin
            flash[sweep] <= ERASED_WORD; // R02
        end else if (state == ST_PAGE) begin
            flash[FLASH_AW'({page, sweep[PAGE_AW-1:0]})] <=
                {pbuf_hi[sweep[PAGE_AW-1:0]],
                 pbuf_lo[sweep[PAGE_AW-1:0]]}; // R12
        end
    end

    // EEPROM page buffer with a mask of loaded bytes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            emask <= '0;
        end else if (go && cur.op == OP_LD_EE) begin
            emask[cur.b3[EE_PAGE_AW-1:0]] <= 1'b1;
        end else if (go && cur.op == OP_WR_EEPG) begin
            emask <= '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (go && cur.op == OP_LD_EE) begin
            ebuf[cur.b3[EE_PAGE_AW-1:0]] <= cur.b4;
        end
    end

    // EEPROM array; a write replaces the byte, so no erase is needed first
    always_ff @(posedge mclk) begin
        if (state == ST_ERASE) begin
            ee[sweep[EE_AW-1:0]] <= ERASED_BYTE; // R02
        end else if (go && cur.op == OP_WR_EE) begin
            ee[ee_addr] <= cur.b4; // R03 R14
        end else if (go && cur.op == OP_WR_EEPG) begin
            for (int i = 0; i < 4; i++) begin
                if (emask[i]) begin
                    ee[{ee_addr[EE_AW-1:EE_PAGE_AW], 2'(i)}] <= ebuf[i]; // R15
                end
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_second_enable_byte;
        session && byte_done && byte_idx == 2'h1 && rx_byte == OP_ENABLE_2;
    endsequence

    sequence s_ee_read_addr;
        session && byte_done && byte_idx == 2'h2 && b1 == OP_RD_EE;
    endsequence

    sample_in_a: assert property (sck_rise && session |=> // R05
        rx_sh[0] == $past(sdi_q[1]))
        else $error("input bit not sampled on rising clock");
    shift_out_a: assert property (sck_fall && session && !sck_rise |=> // R06
        sdo == $past(tx_sh[7]))
        else $error("output bit not shifted on falling clock");
    enable_echo_a: assert property (s_second_enable_byte |=> // R09
        tx_sh == OP_ENABLE_2)
        else $error("enable echo not loaded");
    ee_read_a: assert property (s_ee_read_addr |=> // R16
        tx_sh == $past(ee[{b2[1:0], rx_byte}]))
        else $error("eeprom read data wrong");
    enable_gate_a: assert property (instr_valid && !prog_enabled // R01
        && state == ST_IDLE |=> state == ST_IDLE)
        else $error("instruction ran before enable");
    erase_fill_a: assert property (state == ST_ERASE |=> // R02
        flash[$past(sweep)] == ERASED_WORD)
        else $error("erase left a word set");
    ee_write_a: assert property (go && cur.op == OP_WR_EE |=> // R03
        ee[$past(ee_addr)] == $past(cur.b4) ##1 write_pending_flag)
        else $error("eeprom byte write failed");
    page_keep_a: assert property (go && cur.op == OP_WR_EEPG // R15
        && !emask[0] |=> ee[{$past(ee_addr[EE_AW-1:2]), 2'h0}]
        == $past(ee[{ee_addr[EE_AW-1:2], 2'h0}]))
        else $error("unloaded eeprom byte changed");
    pending_a: assert property ($rose(state != ST_IDLE) |=> // R17
        write_pending_flag [*2])
        else $error("busy flag not raised");
    frame_a: assert property (fifo_pop && asm_cnt == 2'h3 && session // R25
        |=> instr_valid)
        else $error("fourth byte did not complete instruction");
    fuse_hi_a: assert property (go && cur.op == OP_ENABLE_1 // R19
        && cur.b2 == SUB_FUSE_HI |=> fuse_hi == $past(cur.b4)
        && state == ST_WAIT)
        else $error("fuse high write failed");
endmodule

`default_nettype wire

// [rtl/prog_pkg.sv]
package prog_pkg;
    // Core clock and the self-timed write delays
    localparam int  CLK_PERIOD_NS  = 100;
    localparam real FLASH_WAIT_MS  = 2.6;
    localparam real EEPROM_WAIT_MS = 3.6;
    localparam real ERASE_WAIT_MS  = 10.5;
    localparam real FUSE_WAIT_MS   = 4.5;
    localparam int  FLASH_WAIT_CYC  = int'($ceil(FLASH_WAIT_MS * 1.0e6
                                      / CLK_PERIOD_NS));
    localparam int  EEPROM_WAIT_CYC = int'($ceil(EEPROM_WAIT_MS * 1.0e6
                                      / CLK_PERIOD_NS));
    localparam int  ERASE_WAIT_CYC  = int'($ceil(ERASE_WAIT_MS * 1.0e6
                                      / CLK_PERIOD_NS));
    localparam int  FUSE_WAIT_CYC   = int'($ceil(FUSE_WAIT_MS * 1.0e6
                                      / CLK_PERIOD_NS));

    // Memory geometry
    localparam int PAGE_AW    = 6;
    localparam int PAGE_NUM_W = 7;
    localparam int EE_AW      = 10;
    localparam int EE_PAGE_AW = 2;

    // Instruction bytes
    localparam logic [7:0] OP_ENABLE_1  = 8'hac;
    localparam logic [7:0] OP_ENABLE_2  = 8'h53;
    localparam logic [7:0] SUB_ERASE    = 8'h80;
    localparam logic [7:0] SUB_LOCK     = 8'he0;
    localparam logic [7:0] SUB_FUSE_LO  = 8'ha0;
    localparam logic [7:0] SUB_FUSE_HI  = 8'ha8;
    localparam logic [7:0] SUB_FUSE_EXT = 8'ha4;
    localparam logic [7:0] OP_POLL      = 8'hf0;
    localparam logic [7:0] OP_EXT_ADDR  = 8'h4d;
    localparam logic [7:0] OP_LD_LO     = 8'h40;
    localparam logic [7:0] OP_LD_HI     = 8'h48;
    localparam logic [7:0] OP_LD_EE     = 8'hc1;
    localparam logic [7:0] OP_RD_LO     = 8'h20;
    localparam logic [7:0] OP_RD_HI     = 8'h28;
    localparam logic [7:0] OP_RD_EE     = 8'ha0;
    localparam logic [7:0] OP_RD_LOCKHI = 8'h58;
    localparam logic [7:0] OP_RD_FUSE   = 8'h50;
    localparam logic [7:0] SUB_RD_UPPER = 8'h08;
    localparam logic [7:0] OP_WR_PAGE   = 8'h4c;
    localparam logic [7:0] OP_WR_EE     = 8'hc0;
    localparam logic [7:0] OP_WR_EEPG   = 8'hc2;

    // Erased content and fuse values after reset
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [15:0] ERASED_WORD  = 16'hffff;
    localparam logic [7:0]  LOCK_RST     = 8'hff;
    localparam logic [7:0]  FUSE_LO_RST  = 8'hff;
    localparam logic [7:0]  FUSE_HI_RST  = 8'hff;
    localparam logic [7:0]  FUSE_EXT_RST = 8'hff;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } instr_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PAGE, ST_WAIT}
        exec_state_t;
endpackage

// [tb/prog_host.sv]
`timescale 1ns/1ps
`default_nettype none

// Programmer model: sck rests low between frames, MSB first
module prog_host (
    output logic        sck,
    output logic        sdi,
    input  wire logic   sdo,
    output logic        done,
    output logic [31:0] resp
);
    // Clock held low from power-up so no reset pulse is owed
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        done = 1'b0;
        resp = '0;
    end

    // 800 ns bit period; data flips after its hold so no stale level
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            #100 sdi <= w[i];
            #300 sck <= 1'b1;
            #200 r[i] = sdo;
            #200 sck <= 1'b0;
        end
        #100 sdi <= ~w[0];
        resp = r;
        done = 1'b1;
        #100 done = 1'b0;
        #400;
    endtask
endmodule

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import prog_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        prog_rst_n = 1'b0;
    wire logic   sck, sdi, sdo, prog_enabled, write_pending_flag;
    wire logic   rx_overrun, done;
    wire logic [31:0] resp;
    logic [31:0] r, seed = 32'h0d69;
    logic [9:0]  q[$];
    int          n_fail = 0, n_compared = 0;
    localparam logic [7:0]  WSUB[4] = '{8'he0, 8'ha0, 8'ha8, 8'ha4};
    localparam logic [15:0] RSEL[4] = '{16'h5800, 16'h5000, 16'h5808,
                                        16'h5008};

    always #50 mclk = ~mclk;

    // Short waits and a small flash keep sweeps and polls brief
    spi_prog #(.FLASH_AW(10), .FLASH_WAIT(20), .EEPROM_WAIT(20),
        .ERASE_WAIT(20), .FUSE_WAIT(20)) dut (.mclk(mclk),
        .resetn(resetn), .prog_rst_n(prog_rst_n), .sck(sck), .sdi(sdi),
        .sdo(sdo), .prog_enabled(prog_enabled),
        .write_pending_flag(write_pending_flag), .rx_overrun(rx_overrun));
    prog_host host (.sck(sck), .sdi(sdi), .sdo(sdo), .done(done),
        .resp(resp));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Note goes in first; pos 3 checks byte 4, pos 2 byte 3, 0 none
    task automatic frame(input logic [31:0] w, input logic [1:0] pos,
                         input logic [7:0] exp);
        q.push_back({pos, exp});
        host.xfer(w, r);
    endtask

    // Bounded: a write that never finishes ends the run
    task automatic poll();
        for (int i = 0; i < 40; i++) begin
            frame(32'hf000_0000, 2'd0, 8'h00);
            if (r[7:0] === 8'h00) return;
        end
        n_fail++;
        wrap_up();
    endtask

    // Pairs each finished frame with the oldest note
    always @(posedge done) begin
        logic [9:0] e;
        e = q.pop_front();
        if (e[9:8] == 2'd3) chk(resp[7:0], e[7:0]);
        else if (e[9:8] == 2'd2) chk(resp[15:8], e[7:0]);
    end

    initial begin
        logic [9:0] a;
        logic [7:0] d[4];
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        // Power-up settle kept short; the block needs two clocks for its reset pin synchroniser
        repeat (4) @(posedge mclk);
        frame(32'hac53_0000, 2'd2, 8'h53);
        chk({7'h0, prog_enabled}, 8'h01);
        frame(32'hac80_0000, 2'd0, 8'h00);
        frame(32'hf000_0000, 2'd3, 8'h01);
        // Let the erase sweep end; polling through it overfills the queue
        repeat (1100) @(posedge mclk);
        poll();
        a = 10'(rnd());
        frame({8'h20, 6'h0, a, 8'h00}, 2'd3, 8'hff);
        frame({8'ha0, 6'h0, a, 8'h00}, 2'd3, 8'hff);
        for (int i = 0; i < 3; i++) d[i] = 8'(rnd());
        // Page load, commit from another word of the same page
        frame({8'h40, 10'h0, a[5:0], d[0]}, 2'd0, 8'h00);
        frame({8'h48, 10'h0, a[5:0], d[1]}, 2'd0, 8'h00);
        frame({8'h4c, 6'h0, a[9:6], ~a[5:0], 8'h00}, 2'd0, 8'h00);
        poll();
        // Extended bits lie above the small flash, so reads still hit a
        frame({8'h4d, 8'h00, 8'(rnd()), 8'h00}, 2'd0, 8'h00);
        frame({8'h20, 6'h0, a, 8'h00}, 2'd3, d[0]);
        frame({8'h28, 6'h0, a, 8'h00}, 2'd3, d[1]);
        // Byte writes into an erased page, then a one-byte page commit over the first
        frame({8'hc0, 6'h0, a, d[0]}, 2'd0, 8'h00);
        poll();
        frame({8'hc0, 6'h0, a ^ 10'h1, d[1]}, 2'd0, 8'h00);
        poll();
        frame({8'hc1, 14'h0, a[1:0], d[2]}, 2'd0, 8'h00);
        frame({8'hc2, 6'h0, a[9:2], 2'b00, 8'h00}, 2'd0, 8'h00);
        poll();
        frame({8'ha0, 6'h0, a, 8'h00}, 2'd3, d[2]);
        frame({8'ha0, 6'h0, a ^ 10'h1, 8'h00}, 2'd3, d[1]);
        for (int i = 0; i < 4; i++) begin
            // Top nibble treated as unused, so it stays unprogrammed
            d[i] = 8'(rnd()) | 8'hf0;
            frame({8'hac, WSUB[i], 8'h00, d[i]}, 2'd0, 8'h00);
            poll();
            frame({RSEL[i], 16'h0000}, 2'd3, d[i]);
        end
        // Sweep stalls the queue; twelve bytes overflow eight slots
        frame(32'hac80_0000, 2'd0, 8'h00);
        for (int i = 0; i < 3; i++) frame(32'ha000_0000, 2'd0, 8'h00);
        chk({7'h0, rx_overrun}, 8'h01);
        @(posedge mclk);
        prog_rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        chk({6'h0, rx_overrun, prog_enabled}, 8'h00);
        prog_rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        frame({8'hc0, 6'h0, a, 8'h5a}, 2'd0, 8'h00);
        frame(32'hac53_0000, 2'd2, 8'h53);
        poll();
        frame({8'ha0, 6'h0, a, 8'h00}, 2'd3, 8'hff);
        wrap_up();
    end
endmodule

`default_nettype wire
